// ===== tap_pkg.sv
// Purpose: shared constants and types of the test access port controller
// Assumes: single 4-bit instruction register, LSB-first shift chains
// Notes:   opcodes other than the four private ones are local choices
package tap_pkg;

	// instruction and identification register shapes and fixed capture pattern
	localparam int          IR_WIDTH      = 4;
	localparam logic [3:0]  IR_CAPTURE    = 4'h1;
	localparam int          ID_WIDTH      = 32;

	// instruction opcodes
	localparam logic [3:0]  OP_EXTEST     = 4'h0;
	localparam logic [3:0]  OP_IDCODE     = 4'h1;
	localparam logic [3:0]  OP_SAMPLE     = 4'h2;
	localparam logic [3:0]  OP_PROG_LO    = 4'h4;
	localparam logic [3:0]  OP_PROG_HI    = 4'h7;
	localparam logic [3:0]  OP_PRIV_INT   = 4'h8;
	localparam logic [3:0]  OP_PRIV_BRK   = 4'h9;
	localparam logic [3:0]  OP_PRIV_LO    = 4'h8;
	localparam logic [3:0]  OP_PRIV_HI    = 4'hB;
	localparam logic [3:0]  OP_BYPASS     = 4'hF;

	// identification value, arbitrary, bit 0 set as boundary scan requires
	localparam logic [31:0] ID_DEFAULT    = 32'h0000_0001;

	// reset values of pin-facing outputs
	localparam logic        TDO_RESET     = 1'b0;
	localparam logic [1:0]  SYNC_RESET    = 2'h0;

	// controller states
	typedef enum logic [3:0] {
		ST_RESET, ST_IDLE,
		ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR, ST_EX2_DR, ST_UP_DR,
		ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UP_IR
	} tap_state_e;

	// data register placed between the serial pins
	typedef enum logic [2:0] {
		CH_BYPASS, CH_ID, CH_BSCAN, CH_PROG, CH_INTERNAL, CH_BREAK
	} tap_chain_e;

	// strobes handed to the external scan chains
	typedef struct packed {
		tap_chain_e chain;
		logic       logicReset;
		logic       runIdle;
		logic       captureDr;
		logic       shiftDr;
		logic       updateDr;
	} tap_ctl_s;

	// serial outputs returned by the external scan chains
	typedef struct packed {
		logic bscan;
		logic prog;
		logic internal;
		logic brk;
	} tap_chain_so_s;

endpackage : tap_pkg

// ===== tap_shift_reg.sv
// Purpose: capture/shift/update register used for instruction and data paths
// Assumes: runs on the test clock, synchronous active-low reset
// Notes:   bit 0 is the serial output, serial input enters at the top bit
`timescale 1ns/10ps
module tap_shift_reg #(
	parameter int WIDTH = 4
) (
	// clock and reset
	input  wire logic             tck,
	input  wire logic             rstTck_n,
	// controls
	input  wire logic             capture,
	input  wire logic             shift,
	input  wire logic             update,
	input  wire logic             resetUpd,
	// data
	input  wire logic [WIDTH-1:0] captureVal,
	input  wire logic [WIDTH-1:0] resetVal,
	input  wire logic             serialIn,
	output logic                  serialOut,
	output logic      [WIDTH-1:0] parOut
);

	logic [WIDTH-1:0] shift_q, shift_d;
	logic [WIDTH-1:0] par_q,   par_d;

	////////////////////////////////////////////////////////////////////////////
	// lsb leaves first, new bit enters at msb
	always_comb begin
		shift_d = shift_q;
		par_d   = par_q;
		if (capture) begin
			shift_d = captureVal;
		end else if (shift) begin
			// one expression for every width, so a one-bit register needs no special case
			shift_d = WIDTH'({serialIn, shift_q} >> 1);
		end
		// parallel output moves only on update or reset update, so shifting never glitches users
		if (resetUpd) begin
			par_d = resetVal;
		end else if (update) begin
			par_d = shift_q;
		end
	end

	always_ff @(posedge tck) begin
		if (!rstTck_n) begin
			shift_q <= '0;
			par_q   <= resetVal;
		end else begin
			shift_q <= shift_d;
			par_q   <= par_d;
		end
	end

	assign serialOut = shift_q[0];
	assign parOut    = par_q;

endmodule : tap_shift_reg

// ===== tap_port_ctrl.sv
// Purpose: test access port controller: state machine, instruction register,
//          bypass and identification registers, chain steering, output driver
// Assumes: clk is the core clock, tck the link clock from the external tester
// Notes:   test pins tms/tdi arrive in the tck domain and need no synchroniser
// Contract
// - sixteen-state controller stepped by tms on each rising test clock edge
// - power-on reset puts the controller in Test-Logic-Reset
// - every chain shifts lsb in first and lsb out first
// - instruction is four bits; last bit shifts as tms rises
// - during instruction shift the captured pattern 0x01 leaves on tdo
// - instruction output changes only in Update-IR and Test-Logic-Reset and selects the data path
// - data shift outputs the values captured in Capture-DR
// - latched data register outputs change only in Update-DR
// - exit and pause states do nothing but navigate
// - five tms-high clocks reach Test-Logic-Reset from any state
// - fuse unprogrammed: pins are port pins, controller held in reset
// - enabled port pulls inputs high; tdo driven only while shifting
// - no test reset pin; only power-on reset, port disable or tms sequence
// - data registers: id, bypass, boundary, programming, internal, breakpoint
// - instruction branch may lead into data branch without idle
`timescale 1ns/10ps
module tap_port_ctrl #(
	parameter logic [31:0] ID_CODE = tap_pkg::ID_DEFAULT
) (
	// core clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	// enable sources from the core
	input  wire logic                  test_port_enable_fuse,
	input  wire logic                  test_port_disable_bit,
	// test pins
	input  wire logic                  tck,
	input  wire logic                  tms,
	input  wire logic                  tdi,
	output logic                       tdo,
	output logic                       tdoOe,
	// pad control
	output logic                       pinsArePort,
	output logic                       pullUpEn,
	// external scan chains
	output tap_pkg::tap_ctl_s          chainCtl,
	input  wire tap_pkg::tap_chain_so_s chainSo,
	// current instruction
	output logic [tap_pkg::IR_WIDTH-1:0] instruction
);

	////////////////////////////////////////////////////////////////////////////
	// core domain: port enable and pad mode

	logic enable_q,   enable_d;
	logic portMode_q, portMode_d;
	logic pullUp_q,   pullUp_d;

	// the fuse and disable bit are core-clock levels, so no synchroniser here
	always_comb begin
		enable_d   = test_port_enable_fuse && !test_port_disable_bit;
		portMode_d = !test_port_enable_fuse;
		pullUp_d   = enable_d;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			enable_q   <= 1'b0;
			portMode_q <= 1'b1;
			pullUp_q   <= 1'b0;
		end else begin
			enable_q   <= enable_d;
			portMode_q <= portMode_d;
			pullUp_q   <= pullUp_d;
		end
	end

	assign pinsArePort = portMode_q;
	assign pullUpEn    = pullUp_q;

	////////////////////////////////////////////////////////////////////////////
	// crossing into tck: reset and enable as one level, two flops
	// there is no test reset pin; core reset or disable hold the controller

	logic       runLevel;
	logic [1:0] runSync_q, runSync_d;
	logic       rstTck_n;

	assign runLevel = rst_n && enable_q;

	always_comb begin
		runSync_d = {runSync_q[0], runLevel};
	end

	// synchronous clear keeps the chain free of asynchronous paths
	always_ff @(posedge tck) begin
		runSync_q <= runSync_d;
	end

	assign rstTck_n = runSync_q[1];

	////////////////////////////////////////////////////////////////////////////
	// controller state machine

	tap_pkg::tap_state_e state_q, state_d;

	always_comb begin
		state_d = state_q;
		case (state_q)
			tap_pkg::ST_RESET:  state_d = tms ? tap_pkg::ST_RESET  : tap_pkg::ST_IDLE;
			tap_pkg::ST_IDLE:   state_d = tms ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
			tap_pkg::ST_SEL_DR: state_d = tms ? tap_pkg::ST_SEL_IR : tap_pkg::ST_CAP_DR;
			tap_pkg::ST_CAP_DR: state_d = tms ? tap_pkg::ST_EX1_DR : tap_pkg::ST_SH_DR;
			tap_pkg::ST_SH_DR:  state_d = tms ? tap_pkg::ST_EX1_DR : tap_pkg::ST_SH_DR;
			tap_pkg::ST_EX1_DR: state_d = tms ? tap_pkg::ST_UP_DR  : tap_pkg::ST_PA_DR;
			tap_pkg::ST_PA_DR:  state_d = tms ? tap_pkg::ST_EX2_DR : tap_pkg::ST_PA_DR;
			tap_pkg::ST_EX2_DR: state_d = tms ? tap_pkg::ST_UP_DR  : tap_pkg::ST_SH_DR;
			tap_pkg::ST_UP_DR:  state_d = tms ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
			// tms high from select-ir is the fifth step of the reset walk
			tap_pkg::ST_SEL_IR: state_d = tms ? tap_pkg::ST_RESET  : tap_pkg::ST_CAP_IR;
			tap_pkg::ST_CAP_IR: state_d = tms ? tap_pkg::ST_EX1_IR : tap_pkg::ST_SH_IR;
			tap_pkg::ST_SH_IR:  state_d = tms ? tap_pkg::ST_EX1_IR : tap_pkg::ST_SH_IR;
			tap_pkg::ST_EX1_IR: state_d = tms ? tap_pkg::ST_UP_IR  : tap_pkg::ST_PA_IR;
			tap_pkg::ST_PA_IR:  state_d = tms ? tap_pkg::ST_EX2_IR : tap_pkg::ST_PA_IR;
			tap_pkg::ST_EX2_IR: state_d = tms ? tap_pkg::ST_UP_IR  : tap_pkg::ST_SH_IR;
			// update-ir may go straight on to select-dr, skipping idle
			tap_pkg::ST_UP_IR:  state_d = tms ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
			default:            state_d = tap_pkg::ST_RESET;
		endcase
	end

	// stepped only on the rising test clock edge
	always_ff @(posedge tck) begin
		if (!rstTck_n) begin
			state_q <= tap_pkg::ST_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// state decode; exit and pause states raise none of these

	logic inReset, capIr, shIr, upIr, capDr, shDr, upDr;

	always_comb begin
		inReset = (state_q == tap_pkg::ST_RESET);
		capIr   = (state_q == tap_pkg::ST_CAP_IR);
		shIr    = (state_q == tap_pkg::ST_SH_IR);
		upIr    = (state_q == tap_pkg::ST_UP_IR);
		capDr   = (state_q == tap_pkg::ST_CAP_DR);
		shDr    = (state_q == tap_pkg::ST_SH_DR);
		upDr    = (state_q == tap_pkg::ST_UP_DR);
	end

	////////////////////////////////////////////////////////////////////////////
	// instruction register: captures 0x01, latches in update-ir, loads idcode in test-logic-reset

	logic                         irSo;
	logic [tap_pkg::IR_WIDTH-1:0] irPar;

	tap_shift_reg #(
		.WIDTH      (tap_pkg::IR_WIDTH)
	) u_ir (
		.tck        (tck),
		.rstTck_n   (rstTck_n),
		.capture    (capIr),
		.shift      (shIr),
		.update     (upIr),
		.resetUpd   (inReset),
		.captureVal (tap_pkg::IR_CAPTURE),
		.resetVal   (tap_pkg::OP_IDCODE),
		.serialIn   (tdi),
		.serialOut  (irSo),
		.parOut     (irPar)
	);

	assign instruction = irPar;

	////////////////////////////////////////////////////////////////////////////
	// path selection from the latched instruction

	tap_pkg::tap_chain_e chainSel;

	// unknown opcodes fall to bypass so the chain length stays defined
	always_comb begin
		if (irPar == tap_pkg::OP_IDCODE) begin
			chainSel = tap_pkg::CH_ID;
		end else if (irPar == tap_pkg::OP_EXTEST || irPar == tap_pkg::OP_SAMPLE) begin
			chainSel = tap_pkg::CH_BSCAN;
		end else if (irPar >= tap_pkg::OP_PROG_LO && irPar <= tap_pkg::OP_PROG_HI) begin
			chainSel = tap_pkg::CH_PROG;
		end else if (irPar == tap_pkg::OP_PRIV_INT) begin
			chainSel = tap_pkg::CH_INTERNAL;
		end else if (irPar >= tap_pkg::OP_PRIV_BRK && irPar <= tap_pkg::OP_PRIV_HI) begin
			chainSel = tap_pkg::CH_BREAK;
		end else begin
			chainSel = tap_pkg::CH_BYPASS;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// local data registers: bypass and identification

	logic                         byCap, bySh, idCap, idSh;
	logic                         bySo, idSo;

	always_comb begin
		byCap = capDr && (chainSel == tap_pkg::CH_BYPASS);
		bySh  = shDr  && (chainSel == tap_pkg::CH_BYPASS);
		idCap = capDr && (chainSel == tap_pkg::CH_ID);
		idSh  = shDr  && (chainSel == tap_pkg::CH_ID);
	end

	tap_shift_reg #(
		.WIDTH      (1)
	) u_bypass (
		.tck        (tck),
		.rstTck_n   (rstTck_n),
		.capture    (byCap),
		.shift      (bySh),
		.update     (1'b0),
		.resetUpd   (1'b0),
		.captureVal (1'b0),
		.resetVal   (1'b0),
		.serialIn   (tdi),
		.serialOut  (bySo),
		.parOut     ()
	);

	tap_shift_reg #(
		.WIDTH      (tap_pkg::ID_WIDTH)
	) u_id (
		.tck        (tck),
		.rstTck_n   (rstTck_n),
		.capture    (idCap),
		.shift      (idSh),
		.update     (1'b0),
		.resetUpd   (1'b0),
		.captureVal (ID_CODE),
		.resetVal   ('0),
		.serialIn   (tdi),
		.serialOut  (idSo),
		.parOut     ()
	);

	////////////////////////////////////////////////////////////////////////////
	// strobes to the external chains, registered from the next state so they
	// stand high exactly while the controller sits in that state

	tap_pkg::tap_ctl_s ctl_q, ctl_d;

	always_comb begin
		ctl_d            = '0;
		ctl_d.chain      = chainSel;
		ctl_d.logicReset = (state_d == tap_pkg::ST_RESET);
		ctl_d.runIdle    = (state_d == tap_pkg::ST_IDLE);
		ctl_d.captureDr  = (state_d == tap_pkg::ST_CAP_DR);
		ctl_d.shiftDr    = (state_d == tap_pkg::ST_SH_DR);
		ctl_d.updateDr   = (state_d == tap_pkg::ST_UP_DR);
		// instruction changes in update-ir, one edge before select-dr, and in test-logic-reset
		if (state_q == tap_pkg::ST_UP_IR || state_q == tap_pkg::ST_RESET) begin
			ctl_d.chain = tap_pkg::CH_BYPASS;
		end
	end

	always_ff @(posedge tck) begin
		if (!rstTck_n) begin
			ctl_q            <= '0;
			ctl_q.logicReset <= 1'b1;
		end else begin
			ctl_q            <= ctl_d;
		end
	end

	assign chainCtl = ctl_q;

	////////////////////////////////////////////////////////////////////////////
	// serial output: chosen at the falling edge, driven only while shifting

	logic tdo_q,   tdo_d;
	logic tdoOe_q, tdoOe_d;
	logic drSo;

	always_comb begin
		case (chainSel)
			tap_pkg::CH_ID:       drSo = idSo;
			tap_pkg::CH_BSCAN:    drSo = chainSo.bscan;
			tap_pkg::CH_PROG:     drSo = chainSo.prog;
			tap_pkg::CH_INTERNAL: drSo = chainSo.internal;
			tap_pkg::CH_BREAK:    drSo = chainSo.brk;
			default:              drSo = bySo;
		endcase
		tdoOe_d = shIr || shDr;
		if (shIr) begin
			tdo_d = irSo;
		end else if (shDr) begin
			tdo_d = drSo;
		end else begin
			tdo_d = tap_pkg::TDO_RESET;
		end
	end

	// falling edge gives the tester half a period of setup for its next rise
	always_ff @(negedge tck) begin
		if (!rstTck_n) begin
			tdo_q   <= tap_pkg::TDO_RESET;
			tdoOe_q <= 1'b0;
		end else begin
			tdo_q   <= tdo_d;
			tdoOe_q <= tdoOe_d;
		end
	end

	assign tdo   = tdo_q;
	assign tdoOe = tdoOe_q;

endmodule : tap_port_ctrl

// ===== tap_port_ctrl_properties.sv
// Purpose: port-level assertions for the test access port controller
// Assumes: chainCtl mirrors the controller state; clk and tck unrelated
// Notes:   tck checks other than AST_TMS_RESET and AST_FUSE_HOLD wait a few edges after the port is enabled
`timescale 1ns/10ps
module tap_port_ctrl_properties (
	// clocks and reset
	input wire logic                         clk,
	input wire logic                         rst_n,
	input wire logic                         tck,
	// enables and link pins
	input wire logic                         test_port_enable_fuse,
	input wire logic                         test_port_disable_bit,
	input wire logic                         tms,
	input wire logic                         tdi,
	input wire logic                         tdo,
	input wire logic                         tdoOe,
	// pad and chain side
	input wire logic                         pinsArePort,
	input wire logic                         pullUpEn,
	input wire tap_pkg::tap_ctl_s            chainCtl,
	input wire tap_pkg::tap_chain_so_s       chainSo,
	input wire logic [tap_pkg::IR_WIDTH-1:0] instruction
);
	logic [2:0] liveCnt_q = 3'h0;
	logic [2:0] liveCnt_d;
	logic       live;

	// the enable reaches tck through two flops, so tck checks gated by live start late
	always_comb begin
		liveCnt_d = liveCnt_q;
		if (!(rst_n && test_port_enable_fuse && !test_port_disable_bit)) liveCnt_d = 3'h0;
		else if (liveCnt_q != 3'h4) liveCnt_d = liveCnt_q + 3'h1;
	end
	always_ff @(posedge tck) begin
		liveCnt_q <= liveCnt_d;
	end
	assign live = (liveCnt_q == 3'h4);

	////////////////////////////////////////
	// entry walks from idle
	sequence irEntry;
		chainCtl.runIdle && tms ##1 tms ##1 !tms ##1 !tms;
	endsequence
	sequence drEntry;
		chainCtl.runIdle && tms ##1 !tms ##1 !tms;
	endsequence

	AST_TMS_RESET: assert property (@(posedge tck) disable iff (!rst_n)
		tms [*5] |=> chainCtl.logicReset) else $error("tms high run missed reset");
	AST_LEAVE_RESET: assert property (@(posedge tck) disable iff (!live)
		chainCtl.logicReset && !tms |=> chainCtl.runIdle) else $error("reset exit wrong");
	AST_IR_ENTRY: assert property (@(posedge tck) disable iff (!live)
		irEntry |=> tdoOe && tdo) else $error("instruction shift entry wrong");
	AST_DR_ENTRY: assert property (@(posedge tck) disable iff (!live)
		drEntry |=> chainCtl.shiftDr && tdoOe) else $error("data shift entry wrong");
	AST_TDO_FLOAT: assert property (@(posedge tck) disable iff (!live)
		chainCtl.runIdle || chainCtl.captureDr || chainCtl.updateDr |-> !tdoOe)
		else $error("tdo driven outside shift");
	AST_TDO_DRIVE: assert property (@(posedge tck) disable iff (!live)
		chainCtl.shiftDr |-> tdoOe) else $error("tdo not driven in data shift");
	AST_IR_UPDATE: assert property (@(posedge tck) disable iff (!live)
		!chainCtl.logicReset && $changed(instruction)
		|-> chainCtl.chain == tap_pkg::CH_BYPASS) else $error("instruction moved early");
	AST_CAPTURE_STEP: assert property (@(posedge tck) disable iff (!live)
		chainCtl.captureDr |=> chainCtl.shiftDr == !$past(tms)) else $error("capture exit wrong");
	AST_UPDATE_STEP: assert property (@(posedge tck) disable iff (!live)
		chainCtl.updateDr && !tms |=> chainCtl.runIdle) else $error("update exit wrong");
	AST_CHAIN_TDO: assert property (@(posedge tck) disable iff (!live)
		chainCtl.shiftDr && chainCtl.chain == tap_pkg::CH_BSCAN |-> tdo == chainSo.bscan)
		else $error("boundary chain bit not on tdo");
	AST_BYPASS_TDO: assert property (@(posedge tck) disable iff (!live)
		chainCtl.shiftDr && chainCtl.chain == tap_pkg::CH_BYPASS && $past(chainCtl.shiftDr)
		|-> tdo == $past(tdi)) else $error("bypass bit not on tdo");
	AST_FUSE_HOLD: assert property (@(posedge tck) disable iff (!rst_n)
		!test_port_enable_fuse [*4] |-> chainCtl.logicReset) else $error("not held in reset");
	AST_FUSE_PINS: assert property (@(posedge clk) disable iff (!rst_n)
		!test_port_enable_fuse |=> pinsArePort && !pullUpEn) else $error("port pins wrong");
	AST_PULL_UP: assert property (@(posedge clk) disable iff (!rst_n)
		test_port_enable_fuse && !test_port_disable_bit |=> !pinsArePort && pullUpEn)
		else $error("pull-ups wrong");
endmodule : tap_port_ctrl_properties

bind tap_port_ctrl tap_port_ctrl_properties u_props (.clk(clk), .rst_n(rst_n), .tck(tck),
	.test_port_enable_fuse(test_port_enable_fuse), .test_port_disable_bit(test_port_disable_bit),
	.tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe), .pinsArePort(pinsArePort),
	.pullUpEn(pullUpEn), .chainCtl(chainCtl), .chainSo(chainSo), .instruction(instruction));

// ===== tap_tester_model.sv
// Purpose: behavioural external test controller driving the link pins
// Assumes: tck stands still low between frames, 64 ns period inside them
// Notes:   a released tdo reads high, as the board pull-up makes it
`timescale 1ns/10ps
module tap_tester_model (
	// pins driven toward the port
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	// pins returned by the port
	input  wire logic tdo,
	input  wire logic tdoOe
);
	// park the link: clock low, mode select high
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end

	// one test clock period; pins move just after the falling edge
	task automatic pulse(input logic m, input logic d, output logic so);
		tms = m;
		tdi = d;
		#32;
		so = tdoOe ? tdo : 1'b1;
		tck = 1'b1;
		#32;
		tck = 1'b0;
	endtask : pulse

	// mode-select walk of n steps, lsb of seq first
	task automatic walk(input int n, input logic [7:0] seq);
		logic s;
		for (int i = 0; i < n; i++) pulse(seq[i], ~seq[i], s);
	endtask : walk

	// shift n bits lsb first; the last one leaves with tms high
	task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout);
		logic b;
		dout = 32'h0;
		for (int i = 0; i < n; i++) begin
			pulse(i == n - 1, din[i], b);
			dout[i] = b;
		end
	endtask : shift
endmodule : tap_tester_model

// ===== tb_top.sv
// Purpose: self-checking bench for the test access port controller
// Assumes: the tester model drives the link, chains answer at random
// Notes:   stimulus from an lfsr with a fixed start value
`timescale 1ns/10ps
module tb_top;
	logic                   clk = 1'b0;
	logic                   rst_n, fuse, dis, tck, tms, tdi, tdo, tdoOe;
	logic                   pinsArePort, pullUpEn, extOn;
	logic [3:0]             instruction;
	logic [31:0]            lfsrQ, got, hold;
	tap_pkg::tap_ctl_s      chainCtl;
	tap_pkg::tap_chain_so_s chainSo, soFall;
	int                     mismatches, checks;

	tap_port_ctrl DUT (.clk(clk), .rst_n(rst_n), .test_port_enable_fuse(fuse),
		.test_port_disable_bit(dis), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
		.tdoOe(tdoOe), .pinsArePort(pinsArePort), .pullUpEn(pullUpEn),
		.chainCtl(chainCtl), .chainSo(chainSo), .instruction(instruction));
	tap_tester_model tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe));

	// core clock, 50 ns period
	always #25 clk = ~clk;

	////////////////////////////////////////
	function automatic logic [31:0] lfsrNext(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsrNext
	// data path an opcode should select; unlisted codes fall to bypass
	function automatic tap_pkg::tap_chain_e chainOf(input logic [3:0] op);
		case (op)
			4'h0, 4'h2: return tap_pkg::CH_BSCAN;
			4'h1: return tap_pkg::CH_ID;
			4'h4, 4'h5, 4'h6, 4'h7: return tap_pkg::CH_PROG;
			4'h8: return tap_pkg::CH_INTERNAL;
			4'h9, 4'hA, 4'hB: return tap_pkg::CH_BREAK;
			default: return tap_pkg::CH_BYPASS;
		endcase
	endfunction : chainOf
	function automatic logic pick(input tap_pkg::tap_chain_so_s s, input tap_pkg::tap_chain_e c);
		case (c)
			tap_pkg::CH_PROG: return s.prog;
			tap_pkg::CH_INTERNAL: return s.internal;
			tap_pkg::CH_BREAK: return s.brk;
			default: return s.bscan;
		endcase
	endfunction : pick
	task automatic cmpVec(input string what, input logic [31:0] exp, input logic [31:0] seen);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : cmpVec
	task automatic cmpBit(input string what, input logic exp, input logic seen);
		cmpVec(what, {31'h0, exp}, {31'h0, seen});
	endtask : cmpBit
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : end_sim

	////////////////////////////////////////
	// chains shift on the rising test clock, so their serial bit moves there
	always @(posedge tck) begin
		lfsrQ = lfsrNext(lfsrQ);
		chainSo <= tap_pkg::tap_chain_so_s'(lfsrQ[3:0]);
	end
	// tdo launched at a falling edge must carry the chain bit of that moment
	always @(negedge tck) soFall = chainSo;
	always @(posedge tck) if (extOn && chainCtl.shiftDr)
		cmpBit("tdoChain", pick(soFall, chainCtl.chain), tdo);
	// tdo may only move while the test clock is low
	always @(tdo) if (rst_n) cmpBit("tdoEdge", 1'b0, tck);
	// a hung sequence still reaches the verdict
	initial begin
		repeat (100000) @(posedge clk);
		cmpBit("watchdog", 1'b1, 1'b0);
		end_sim;
	end

	////////////////////////////////////////
	initial begin
		rst_n = 1'b0;
		fuse = 1'b1;
		dis = 1'b0;
		extOn = 1'b0;
		chainSo = '0;
		lfsrQ = 32'h0001_1B72;
		mismatches = 0;
		checks = 0;
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		tester.walk(5, 8'h1F);
		cmpVec("instrReset", {28'h0, tap_pkg::OP_IDCODE}, {28'h0, instruction});
		cmpBit("inReset", 1'b1, chainCtl.logicReset);
		cmpBit("pullUp", 1'b1, pullUpEn);
		cmpBit("portPins", 1'b0, pinsArePort);
		// fuse off, then port disabled: controller must stay put
		for (int k = 0; k < 2; k++) begin
			@(negedge clk);
			fuse = k[0];
			dis = k[0];
			repeat (2) @(negedge clk);
			cmpBit("pinsPort", !fuse, pinsArePort);
			cmpBit("pullOff", 1'b0, pullUpEn);
			tester.walk(4, 8'h00);
			cmpBit("heldReset", 1'b1, chainCtl.logicReset);
		end
		@(negedge clk);
		dis = 1'b0;
		repeat (2) @(negedge clk);
		tester.walk(4, 8'h07);
		// every opcode: load, select, scan; odd ones pass through idle
		for (int op = 0; op < 16; op++) begin
			hold = {28'h0, instruction};
			tester.walk(4, 8'h03);
			tester.shift(4, 32'(op), got);
			cmpVec("irCapture", {28'h0, tap_pkg::IR_CAPTURE}, got);
			cmpVec("irHeld", hold, {28'h0, instruction});
			tester.walk(1, 8'h01);
			if (op[0]) tester.walk(1, 8'h00);
			tester.walk(3, 8'h01);
			cmpVec("instr", 32'(op), {28'h0, instruction});
			cmpVec("chain", {29'h0, chainOf(op[3:0])}, {29'h0, chainCtl.chain});
			lfsrQ = lfsrNext(lfsrQ);
			hold = lfsrQ;
			case (chainOf(op[3:0]))
				tap_pkg::CH_ID: begin
					tester.shift(16, hold, got);
					tester.walk(4, 8'h04);
					hold = got;
					tester.shift(16, 32'h0, got);
					cmpVec("idRead", tap_pkg::ID_DEFAULT, {got[15:0], hold[15:0]});
				end
				tap_pkg::CH_BYPASS: begin
					tester.shift(8, hold, got);
					cmpVec("bypass", {24'h0, hold[6:0], 1'b0}, got);
				end
				default: begin
					extOn = 1'b1;
					tester.shift(8, hold, got);
					extOn = 1'b0;
				end
			endcase
			tester.walk(1, 8'h01);
			cmpBit("updateDr", 1'b1, chainCtl.updateDr);
			tester.walk(1, 8'h00);
			cmpBit("backIdle", 1'b1, chainCtl.runIdle);
		end
		// second reset in mid-run with tms low, as a debugger pulling the system reset
		@(negedge clk);
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		tester.walk(3, 8'h00);
		cmpBit("midReset", 1'b1, chainCtl.logicReset);
		cmpVec("midInstr", {28'h0, tap_pkg::OP_IDCODE}, {28'h0, instruction});
		@(negedge clk);
		rst_n = 1'b1;
		tester.walk(4, 8'h07);
		// random walks, then five tms-high clocks
		for (int k = 0; k < 24; k++) begin
			lfsrQ = lfsrNext(lfsrQ);
			hold = lfsrQ;
			tester.walk(int'(hold[2:0]), hold[15:8]);
			tester.walk(5, 8'h1F);
			cmpBit("tmsReset", 1'b1, chainCtl.logicReset);
		end
		end_sim;
	end
endmodule : tb_top
